// ### pkg/uioc_pkg.sv
// constants for the uart i/o pin configuration and output port block
`default_nettype none
package uioc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SET_A = 8'h10;
  localparam logic [7:0] IDX_CLR_A = 8'h11;
  localparam logic [7:0] IDX_CFG_0 = 8'h12;
  localparam logic [7:0] IDX_CFG_1 = 8'h14;
  localparam logic [7:0] IDX_SET_B = 8'h18;
  localparam logic [7:0] IDX_CLR_B = 8'h19;
  localparam logic [7:0] IDX_CFG_2 = 8'h1A;
  localparam logic [7:0] IDX_CFG_3 = 8'h1C;
  // writable bits of each configuration register
  localparam logic [7:0] CFG_0_MASK = 8'hFF;
  localparam logic [7:0] CFG_1_MASK = 8'hFF;
  localparam logic [7:0] CFG_2_MASK = 8'hF3;
  localparam logic [7:0] CFG_3_MASK = 8'h33;
  // values after reset
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] OPR_RESET = 8'h00;
  // pin field codes
  localparam logic [1:0] CODE_INPUT = 2'h0;
  localparam logic [1:0] CODE_PORT = 2'h1;
  localparam logic [1:0] CODE_ALT10 = 2'h2;
  localparam logic [1:0] CODE_ALT11 = 2'h3;
  // per-pin availability of dedicated functions
  localparam logic [7:0] A_EN10 = 8'h9C;
  localparam logic [7:0] A_EN11 = 8'h00;
  localparam logic [7:0] A_OD10 = 8'h00;
  localparam logic [7:0] B_EN10 = 8'h54;
  localparam logic [7:0] B_EN11 = 8'h0C;
  localparam logic [7:0] B_OD10 = 8'h50;
  localparam logic [7:0] B_OD11 = 8'h0C;
  // axi4-lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // least address width to reach the highest register
  localparam int MIN_ADDR_WIDTH = 7;
endpackage
`default_nettype wire

// ### design/uioc_pin_drive.sv
// one pin: output level and enable from its field code
`default_nettype none
module uioc_pin_drive #(
  parameter bit EN10 = 1'b0,
  parameter bit EN11 = 1'b0,
  parameter bit OD10 = 1'b0,
  parameter bit OD11 = 1'b0
) (
  input wire logic [1:0] code,
  input wire logic port_bit,
  input wire logic src10,
  input wire logic src11,
  output logic pin_out,
  output logic pin_oe
);
  wire logic sel_port = (code == uioc_pkg::CODE_PORT); // R14
  wire logic sel10 = (code == uioc_pkg::CODE_ALT10) && EN10; // R18
  wire logic sel11 = (code == uioc_pkg::CODE_ALT11) && EN11; // R18
  // open drain only pulls low when its source is low
  wire logic od = (sel10 && OD10) || (sel11 && OD11);
  wire logic src = sel10 ? src10 : src11;

  always_comb
  begin
    pin_out = 1'b0;
    pin_oe = 1'b0; // R16
    if (sel_port)
    begin
      pin_out = ~port_bit; // R13
      pin_oe = 1'b1;
    end
    else if (od)
    begin
      pin_out = 1'b0;
      pin_oe = ~src;
    end
    else if (sel10 || sel11)
    begin
      pin_out = src;
      pin_oe = 1'b1;
    end
  end
endmodule // uioc_pin_drive
`default_nettype wire

// ### design/uioc_top.sv
// uart i/o pin configuration, output port and axi4-lite register slave
//
// Overview of operation
// R1 - pin 3A: input, port bit 3, 16x tx clock
// R2 - pin 2A: input, port bit 2, 1x tx clock
// R3 - pin 7A: input, port bit 7, B 1x tx clock
// R4 - pin 6A: input or port bit 6 only
// R5 - pin 4A: input, port bit 4, 16x rx clock
// R6 - pin 3B: input, port bit 3, open-drain timer 0
// R7 - pin 2B: input, port bit, rx clock, timer 1
// R8 - config 3 bits 7:6, 3:2 read zero
// R9 - pin 6B: input, port bit 6, tx interrupt
// R10 - pin 4B: input, port bit 4, rx interrupt
// R11 - set port writes force marked bits one
// R12 - clear port writes force marked bits zero
// R13 - port-driven pins carry the inverted bit
// R14 - port bit drives pin only on code 01
// R15 - output port unreadable, set/clear only
// R16 - inputs always live; 00 disables driver
// R17 - reset clears configuration, all pins input
// R18 - reserved codes leave driver off
// R19 - reset clears output port, pins high
//
// Our own choice: register access over AXI4-Lite.
`default_nettype none
module uioc_top #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic transmit_clock_16x,
  input wire logic transmit_clock_1x,
  input wire logic transmit_clock_1x_b,
  input wire logic receive_clock_16x,
  input wire logic receive_clock_1x,
  input wire logic timer_0_out,
  input wire logic timer_1_out,
  input wire logic transmit_interrupt_out,
  input wire logic receive_interrupt_out,
  input wire logic [7:0] pin_a_in,
  output logic [7:0] pin_a_out,
  output logic [7:0] pin_a_oe,
  input wire logic [7:0] pin_b_in,
  output logic [7:0] pin_b_out,
  output logic [7:0] pin_b_oe,
  output logic [7:0] general_input_a,
  output logic [7:0] general_input_b
);
  generate
    if (ADDR_WIDTH < uioc_pkg::MIN_ADDR_WIDTH)
    begin : g_bad_width
      $error("ADDR_WIDTH too small for the register map");
    end
  endgenerate

  // word index of a byte address
  function automatic logic [ADDR_WIDTH-3:0] word_of(input logic [ADDR_WIDTH-1:0] addr);
    word_of = addr[ADDR_WIDTH-1:2];
  endfunction

  // does a byte address select a given register index
  function automatic logic hits(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] idx);
    hits = (word_of(addr) == (ADDR_WIDTH-2)'(idx));
  endfunction

  // reset release through two flip-flops
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // state
  logic [7:0] pin_config_0;
  logic [7:0] pin_config_1;
  logic [7:0] pin_config_2;
  logic [7:0] pin_config_3;
  logic [7:0] output_port_a;
  logic [7:0] output_port_b;
  logic aw_held;
  logic w_held;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;

  // write channel handshakes
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic do_write = aw_held && w_held && !s_axi_bvalid;
  wire logic b_done = s_axi_bvalid && s_axi_bready;
  wire logic next_aw_held = aw_take || (aw_held && !do_write);
  wire logic next_w_held = w_take || (w_held && !do_write);

  // write decode
  wire logic wr_set_a = do_write && w_lane0 && hits(aw_addr, uioc_pkg::IDX_SET_A);
  wire logic wr_clr_a = do_write && w_lane0 && hits(aw_addr, uioc_pkg::IDX_CLR_A);
  wire logic wr_set_b = do_write && w_lane0 && hits(aw_addr, uioc_pkg::IDX_SET_B);
  wire logic wr_clr_b = do_write && w_lane0 && hits(aw_addr, uioc_pkg::IDX_CLR_B);
  wire logic wr_cfg_0 = do_write && w_lane0 && hits(aw_addr, uioc_pkg::IDX_CFG_0);
  wire logic wr_cfg_1 = do_write && w_lane0 && hits(aw_addr, uioc_pkg::IDX_CFG_1);
  wire logic wr_cfg_2 = do_write && w_lane0 && hits(aw_addr, uioc_pkg::IDX_CFG_2);
  wire logic wr_cfg_3 = do_write && w_lane0 && hits(aw_addr, uioc_pkg::IDX_CFG_3);
  wire logic wr_mapped = hits(aw_addr, uioc_pkg::IDX_SET_A) || hits(aw_addr, uioc_pkg::IDX_CLR_A)
    || hits(aw_addr, uioc_pkg::IDX_SET_B) || hits(aw_addr, uioc_pkg::IDX_CLR_B)
    || hits(aw_addr, uioc_pkg::IDX_CFG_0) || hits(aw_addr, uioc_pkg::IDX_CFG_1)
    || hits(aw_addr, uioc_pkg::IDX_CFG_2) || hits(aw_addr, uioc_pkg::IDX_CFG_3);

  // output port next values
  wire logic [7:0] next_port_a = wr_set_a ? (output_port_a | w_byte) // R11
    : wr_clr_a ? (output_port_a & ~w_byte) // R12
    : output_port_a; // R15
  wire logic [7:0] next_port_b = wr_set_b ? (output_port_b | w_byte) // R11
    : wr_clr_b ? (output_port_b & ~w_byte) // R12
    : output_port_b; // R15

  // read channel
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic r_done = s_axi_rvalid && s_axi_rready;
  wire logic next_rvalid = ar_take || (s_axi_rvalid && !r_done);
  wire logic rd_cfg_0 = hits(s_axi_araddr, uioc_pkg::IDX_CFG_0);
  wire logic rd_cfg_1 = hits(s_axi_araddr, uioc_pkg::IDX_CFG_1);
  wire logic rd_cfg_2 = hits(s_axi_araddr, uioc_pkg::IDX_CFG_2);
  wire logic rd_cfg_3 = hits(s_axi_araddr, uioc_pkg::IDX_CFG_3);
  // set and clear ports read as zero; the port value itself never reads
  wire logic rd_wo = hits(s_axi_araddr, uioc_pkg::IDX_SET_A) // R15
    || hits(s_axi_araddr, uioc_pkg::IDX_CLR_A)
    || hits(s_axi_araddr, uioc_pkg::IDX_SET_B)
    || hits(s_axi_araddr, uioc_pkg::IDX_CLR_B);
  wire logic rd_mapped = rd_cfg_0 || rd_cfg_1 || rd_cfg_2 || rd_cfg_3 || rd_wo;
  wire logic [7:0] rd_byte = rd_cfg_0 ? pin_config_0
    : rd_cfg_1 ? pin_config_1
    : rd_cfg_2 ? (pin_config_2 & uioc_pkg::CFG_2_MASK)
    : rd_cfg_3 ? (pin_config_3 & uioc_pkg::CFG_3_MASK) // R8
    : 8'h00;

  // write address and data capture
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= !next_aw_held;
      s_axi_wready <= !next_w_held;
      if (aw_take)
      begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
    end
  end

  // write response
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= uioc_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? uioc_pkg::RESP_OKAY : uioc_pkg::RESP_SLVERR;
    end
    else if (b_done)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration and output port registers
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pin_config_0 <= uioc_pkg::CFG_RESET; // R17
      pin_config_1 <= uioc_pkg::CFG_RESET; // R17
      pin_config_2 <= uioc_pkg::CFG_RESET; // R17
      pin_config_3 <= uioc_pkg::CFG_RESET; // R17
      output_port_a <= uioc_pkg::OPR_RESET; // R19
      output_port_b <= uioc_pkg::OPR_RESET; // R19
    end
    else
    begin
      output_port_a <= next_port_a;
      output_port_b <= next_port_b;
      if (wr_cfg_0)
      begin
        pin_config_0 <= w_byte & uioc_pkg::CFG_0_MASK;
      end
      if (wr_cfg_1)
      begin
        pin_config_1 <= w_byte & uioc_pkg::CFG_1_MASK;
      end
      if (wr_cfg_2)
      begin
        pin_config_2 <= w_byte & uioc_pkg::CFG_2_MASK;
      end
      if (wr_cfg_3)
      begin
        pin_config_3 <= w_byte & uioc_pkg::CFG_3_MASK; // R8
      end
    end
  end

  // read answer
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= uioc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take)
      begin
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_mapped ? uioc_pkg::RESP_OKAY : uioc_pkg::RESP_SLVERR;
      end
    end
  end

  // per-pin field codes; pins without a field see a zero field
  wire logic [15:0] codes_a = {pin_config_1, pin_config_0};
  wire logic [15:0] codes_b = {pin_config_3, pin_config_2};

  // dedicated sources per pin, code 10 and code 11
  wire logic [7:0] src10_a = {transmit_clock_1x_b, 2'b00, receive_clock_16x, // R3 R5
    transmit_clock_16x, transmit_clock_1x, 2'b00}; // R1 R2
  wire logic [7:0] src10_b = {1'b0, ~transmit_interrupt_out, 1'b0, // R9
    ~receive_interrupt_out, 1'b0, receive_clock_1x, 2'b00}; // R10 R7
  wire logic [7:0] src11_b = {4'h0, timer_0_out, timer_1_out, 2'b00}; // R6 R7

  logic [7:0] next_a_out;
  logic [7:0] next_a_oe;
  logic [7:0] next_b_out;
  logic [7:0] next_b_oe;

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_pin
      uioc_pin_drive #(
        .EN10(uioc_pkg::A_EN10[i]),
        .EN11(uioc_pkg::A_EN11[i]),
        .OD10(uioc_pkg::A_OD10[i]),
        .OD11(1'b0)
      ) u_pin_a (
        .code(codes_a[2*i+1:2*i]), // R1 R2 R3 R4 R5 R14
        .port_bit(output_port_a[i]),
        .src10(src10_a[i]),
        .src11(1'b0),
        .pin_out(next_a_out[i]),
        .pin_oe(next_a_oe[i])
      );
      uioc_pin_drive #(
        .EN10(uioc_pkg::B_EN10[i]),
        .EN11(uioc_pkg::B_EN11[i]),
        .OD10(uioc_pkg::B_OD10[i]),
        .OD11(uioc_pkg::B_OD11[i])
      ) u_pin_b (
        .code(codes_b[2*i+1:2*i]), // R6 R7 R9 R10 R14
        .port_bit(output_port_b[i]),
        .src10(src10_b[i]),
        .src11(src11_b[i]),
        .pin_out(next_b_out[i]),
        .pin_oe(next_b_oe[i])
      );
    end
  endgenerate

  // registered pin drive and always-live input sampling
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pin_a_out <= 8'h00;
      pin_a_oe <= 8'h00; // R17
      pin_b_out <= 8'h00;
      pin_b_oe <= 8'h00; // R17
      general_input_a <= 8'h00;
      general_input_b <= 8'h00;
    end
    else
    begin
      pin_a_out <= next_a_out;
      pin_a_oe <= next_a_oe;
      pin_b_out <= next_b_out;
      pin_b_oe <= next_b_oe;
      general_input_a <= pin_a_in; // R16
      general_input_b <= pin_b_in; // R16
    end
  end
endmodule // uioc_top
`default_nettype wire

// ### testbench/uioc_top_sva.sv
// assertions on the ports of the pin configuration block
`default_nettype none
module uioc_top_sva #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [7:0] pin_a_in,
  input wire logic [7:0] pin_a_oe,
  input wire logic [7:0] pin_b_oe,
  input wire logic [7:0] general_input_a
);
  logic [1:0] up;
  logic [5:0] ar_w;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up <= 2'h0;
      ar_w <= 6'h00;
    end
    else
    begin
      if (up != 2'h3)
        up <= up + 2'h1;
      if (s_axi_arvalid && s_axi_arready)
        ar_w <= s_axi_araddr[7:2];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_busy;
    !s_axi_awready && !s_axi_wready;
  endsequence
  property p_wr_steps;
    s_wr_take |=> s_wr_busy ##1 s_axi_bvalid;
  endproperty
  a_wr_steps: assert property (p_wr_steps) else $error("write answer not in two cycles");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer not next cycle");
  property p_rdata_hi;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
  property p_cfg3_zero;
    s_axi_rvalid && ar_w == 6'h1C |-> s_axi_rdata[7:6] == 2'h0 && s_axi_rdata[3:2] == 2'h0;
  endproperty
  a_cfg3_zero: assert property (p_cfg3_zero) else $error("config 3 spare bits set");
  property p_port_hidden;
    s_axi_rvalid && ar_w inside {6'h10, 6'h11, 6'h18, 6'h19} |-> s_axi_rdata == 32'h0;
  endproperty
  a_port_hidden: assert property (p_port_hidden) else $error("output port readable");
  property p_gin;
    up == 2'h3 |=> general_input_a == $past(pin_a_in);
  endproperty
  a_gin: assert property (p_gin) else $error("input copy wrong");
  property p_rst_idle;
    up != 2'h3 |-> pin_a_oe == 8'h00 && pin_b_oe == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pin driven after reset");
  property p_b_never;
    pin_b_oe[7] == 1'h0 && pin_b_oe[5] == 1'h0 && pin_b_oe[1] == 1'h0;
  endproperty
  a_b_never: assert property (p_b_never) else $error("unused b pin driven");
endmodule // uioc_top_sva
bind uioc_top uioc_top_sva #(.ADDR_WIDTH(ADDR_WIDTH)) sva_u (.clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .pin_a_in(pin_a_in), .pin_a_oe(pin_a_oe),
  .pin_b_oe(pin_b_oe), .general_input_a(general_input_a));
`default_nettype wire

// ### testbench/uioc_line_model.sv
// far-side lines on the pins: a released pin shows the outside level
`default_nettype none
module uioc_line_model (
  input wire logic [7:0] out_a,
  input wire logic [7:0] oe_a,
  input wire logic [7:0] ext_a,
  input wire logic [7:0] out_b,
  input wire logic [7:0] oe_b,
  input wire logic [7:0] ext_b,
  output logic [7:0] level_a,
  output logic [7:0] level_b
);
  timeunit 1ns;
  timeprecision 1ps;
  assign level_a = (out_a & oe_a) | (ext_a & ~oe_a);
  assign level_b = (out_b & oe_b) | (ext_b & ~oe_b);
endmodule // uioc_line_model
`default_nettype wire

// ### testbench/uioc_top_bench.sv
// self-checking bench for the pin configuration and output port block
`default_nettype none
module uioc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = uioc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = uioc_pkg::RESP_SLVERR;
  localparam logic [7:0] CFG_I [4] = '{uioc_pkg::IDX_CFG_0, uioc_pkg::IDX_CFG_1,
    uioc_pkg::IDX_CFG_2, uioc_pkg::IDX_CFG_3};
  localparam logic [7:0] CFG_FF [4] = '{8'hFF, 8'hFF, 8'hF3, 8'h33};
  localparam logic [7:0] PORT_I [4] = '{uioc_pkg::IDX_SET_A, uioc_pkg::IDX_CLR_A,
    uioc_pkg::IDX_SET_B, uioc_pkg::IDX_CLR_B};
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ext_a = 8'h3C, ext_b = 8'hFF;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [8:0] src = 9'h000;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] in_a, in_b, out_a, out_b, oe_a, oe_b, gi_a, gi_b;
  int err_total = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  uioc_top dut_u (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .transmit_clock_16x(src[0]), .transmit_clock_1x(src[1]), .transmit_clock_1x_b(src[2]),
    .receive_clock_16x(src[3]), .receive_clock_1x(src[4]), .timer_0_out(src[5]),
    .timer_1_out(src[6]), .transmit_interrupt_out(src[7]), .receive_interrupt_out(src[8]),
    .pin_a_in(in_a), .pin_a_out(out_a), .pin_a_oe(oe_a), .pin_b_in(in_b),
    .pin_b_out(out_b), .pin_b_oe(oe_b), .general_input_a(gi_a), .general_input_b(gi_b));
  uioc_line_model line_u (.out_a(out_a), .oe_a(oe_a), .ext_a(ext_a), .out_b(out_b),
    .oe_b(oe_b), .ext_b(ext_b), .level_a(in_a), .level_b(in_b));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= {idx[5:0], 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (!bvalid);
    bready <= 1'h0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= {idx[5:0], 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'h0;
    end
    while (!rvalid);
    rready <= 1'h0;
    chk("rresp", 32'(er), 32'(rresp));
    chk("rdata", ed, rdata);
  endtask
  task automatic pins(input logic [7:0] eoa, eua, eob, eub);
    repeat (3) @(posedge clk);
    chk("pin_a_oe", 32'(eoa), 32'(oe_a));
    chk("pin_a_out", 32'(eua), 32'(out_a & oe_a));
    chk("pin_b_oe", 32'(eob), 32'(oe_b));
    chk("pin_b_out", 32'(eub), 32'(out_b & oe_b));
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    pins(8'h00, 8'h00, 8'h00, 8'h00);
    @(posedge clk);
    chk("general_input_a", 32'h3C, 32'(gi_a));
    foreach (CFG_I[i])
    begin
      rd(CFG_I[i], 32'h0, OK);
      wr(CFG_I[i], 8'hFF, OK);
      rd(CFG_I[i], 32'(CFG_FF[i]), OK);
    end
    foreach (PORT_I[i])
      rd(PORT_I[i], 32'h0, OK);
    rd(8'h1F, 32'h0, ERR);
    wr(8'h1F, 8'hFF, ERR);
    pins(8'h00, 8'h00, 8'h0C, 8'h00);
    chk("general_input_b", 32'hF3, 32'(gi_b));
    foreach (CFG_I[i])
      wr(CFG_I[i], 8'h55, OK);
    pins(8'hFF, 8'hFF, 8'h5D, 8'h5D);
    wr(PORT_I[0], 8'hA5, OK);
    wr(PORT_I[2], 8'hFF, OK);
    pins(8'hFF, 8'h5A, 8'h5D, 8'h00);
    wr(PORT_I[0], 8'h0F, OK);
    wr(PORT_I[1], 8'h81, OK);
    wr(PORT_I[3], 8'h14, OK);
    pins(8'hFF, 8'hD1, 8'h5D, 8'h14);
    chk("general_input_a", 32'hD1, 32'(gi_a));
    src <= 9'h0F5;
    foreach (CFG_I[i])
      wr(CFG_I[i], 8'hAA, OK);
    pins(8'h9C, 8'h88, 8'h44, 8'h04);
    src <= 9'h10A;
    pins(8'h9C, 8'h14, 8'h14, 8'h00);
    for (int i = 0; i < 3; i++)
      wr(CFG_I[i], 8'hFF, OK);
    src <= 9'h040;
    pins(8'h00, 8'h00, 8'h08, 8'h00);
    wstrb <= 4'hE;
    wr(CFG_I[3], 8'h33, OK);
    wstrb <= 4'hF;
    rd(CFG_I[3], 32'h22, OK);
    rst_n <= 1'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rd(CFG_I[3], 32'h0, OK);
    wr(CFG_I[0], 8'h55, OK);
    pins(8'h0F, 8'h0F, 8'h00, 8'h00);
    summarize();
  end
endmodule // uioc_top_bench
`default_nettype wire
